// ### rtl/strap_capture_pkg.sv
// constants, types and field layout for the strap option capture registers
// assumes the strap pins are stable while reset is asserted and just after
// What this block does
// - each strap register bit loads the level sampled on its strap pin
// - first strap register is read-only at index 04ah of the index/data pair
// - first register bits 7-6 show pins 7,6: pci clock pll range
// - first register bits 5-4 show pins 9,8: system bus mode
// - both mode pins low selects isa expansion mode
// - first register bit 2 shows pin 5: memory/host clock synchronisation
// - first register bits 1-0 show pins 4 and 17: pci clock divider
// - second register is read-only at index 04bh, bits 5-1 reserved
// - second register bits 7-6 show pins 40,14: cpu clock multiplier
// - second register bit 0 shows pin 36: boot device width
// - host pll register is read-only at index 05fh, bits 2-0 reserved
// - host pll register bits 7-6 always read zero
// - host pll register bits 5-3 show pins 26,25,24: host clock code
// - with pins 3,2 low codes 0..3 give 25,50,60,66 mhz host clock
// - third register at index 04ch is read-only except writable bit 4
// - third register bit 7 shows pin 53: parallel port enable
// - third register bit 6 shows pin 52: keyboard controller enable
// - third register bit 4 shows pin 20: dot clock pin direction
// - third register bit 3 shows pin 19: memory clock output drive
// - third register bit 2 shows pin 18: host clock pin direction
// - third register bits 1,0 show pins 51,50: serial ports one and two
// - deskew pins 45,46 select host range 33-64 or 64-133 mhz
// - the deskew pair has no software-readable location
package strap_capture_pkg;

  localparam int unsigned STRAP_PIN_W = 64;
  localparam int unsigned IDX_W       = 8;

  // configuration indices
  localparam logic [7:0] IDX_CLOCK_MODE = 8'h4a;
  localparam logic [7:0] IDX_CPU_BOOT   = 8'h4b;
  localparam logic [7:0] IDX_PERIPH     = 8'h4c;
  localparam logic [7:0] IDX_HOST_PLL   = 8'h5f;

  // strap pin numbers
  localparam int unsigned PIN_HSPD0   = 2;
  localparam int unsigned PIN_HSPD1   = 3;
  localparam int unsigned PIN_PCIDIV0 = 4;
  localparam int unsigned PIN_SYNC    = 5;
  localparam int unsigned PIN_PCIPLL0 = 6;
  localparam int unsigned PIN_PCIPLL1 = 7;
  localparam int unsigned PIN_MODE0   = 8;
  localparam int unsigned PIN_MODE1   = 9;
  localparam int unsigned PIN_MULT0   = 14;
  localparam int unsigned PIN_PCIDIV1 = 17;
  localparam int unsigned PIN_HCLKDIR = 18;
  localparam int unsigned PIN_MCLKDIR = 19;
  localparam int unsigned PIN_DCLKDIR = 20;
  localparam int unsigned PIN_HPLL0   = 24;
  localparam int unsigned PIN_HPLL1   = 25;
  localparam int unsigned PIN_HPLL2   = 26;
  localparam int unsigned PIN_BOOTW   = 36;
  localparam int unsigned PIN_MULT1   = 40;
  localparam int unsigned PIN_DSK0    = 45;
  localparam int unsigned PIN_DSK1    = 46;
  localparam int unsigned PIN_SER2    = 50;
  localparam int unsigned PIN_SER1    = 51;
  localparam int unsigned PIN_KBD     = 52;
  localparam int unsigned PIN_PAR     = 53;

  // writable bit of the peripheral register
  localparam int unsigned DOT_DIR_BIT = 4;

  // mode and code encodings
  localparam logic [1:0] MODE_ISA     = 2'h0;
  localparam logic [1:0] PLL_RANGE_LO = 2'h0;
  localparam logic [1:0] PLL_RANGE_HI = 2'h1;
  localparam logic [1:0] MULT_X1      = 2'h1; // {pin40,pin14}
  localparam logic [1:0] MULT_X2      = 2'h3;
  localparam logic [1:0] DSK_LOW      = 2'h2; // {pin45,pin46}
  localparam logic [1:0] DSK_HIGH     = 2'h1;
  localparam logic [2:0] HPLL_25      = 3'h0;
  localparam logic [2:0] HPLL_50      = 3'h1;
  localparam logic [2:0] HPLL_60      = 3'h2;
  localparam logic [2:0] HPLL_66      = 3'h3;

  // host clock selection handed to the synthesizer
  typedef enum logic [4:0] {
    HCLK_25  = 5'h01,
    HCLK_50  = 5'h02,
    HCLK_60  = 5'h04,
    HCLK_66  = 5'h08,
    HCLK_RSV = 5'h10
  } host_clk_sel_e;

  // decoded strap settings
  typedef struct packed {
    logic [1:0]    pci_pll_range;
    logic          pci_pll_valid;
    logic [1:0]    bus_mode;
    logic          isa_mode;
    logic          mem_host_sync;
    logic [1:0]    pci_div;
    logic [1:0]    cpu_mult;
    logic          cpu_mult_valid;
    logic          boot_16bit;
    logic [2:0]    host_pll_code;
    host_clk_sel_e host_clk_sel;
    logic [1:0]    deskew_code;
    logic          deskew_valid;
    logic          par_en;
    logic          kbd_en;
    logic          ser1_en;
    logic          ser2_en;
  } strap_cfg_s;

  // clock pin direction controls
  typedef struct packed {
    logic dot_clk_drive;
    logic mem_clk_drive;
    logic host_clk_drive;
  } clk_pin_dir_s;

endpackage

// ### rtl/strap_option_capture_regs.sv
// strap option capture registers behind the index/data configuration port
// assumes strap pins hold their levels during reset; index/data port is synchronous
`timescale 1ns/1ps
module strap_option_capture_regs
(
  input  wire logic                                       ref_clk_i,
  input  wire logic                                       reset_n_i,
  input  wire logic [strap_capture_pkg::STRAP_PIN_W-1:0] memory_data_strap_pins_i,
  input  wire logic [strap_capture_pkg::IDX_W-1:0]       cfg_index_i,
  input  wire logic                                       cfg_rd_i,
  input  wire logic                                       cfg_wr_i,
  input  wire logic [7:0]                                 cfg_wdata_i,
  output logic      [7:0]                                 cfg_rdata_o,
  output logic                                            cfg_hit_o,
  output strap_capture_pkg::strap_cfg_s                   strap_cfg_o,
  output strap_capture_pkg::clk_pin_dir_s                 clk_pin_dir_o
);
  import strap_capture_pkg::*;

  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic       captured_reg;
  logic [1:0] hspd_reg;

  logic [7:0] clock_mode_reg;
  logic [7:0] cpu_boot_reg;
  logic [7:0] periph_reg;
  logic [7:0] host_pll_reg;
  logic [1:0] deskew_reg;

  // reset release through two flops
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  wire [STRAP_PIN_W-1:0] p = memory_data_strap_pins_i;

  wire [7:0] clock_mode_next = {p[PIN_PCIPLL1], p[PIN_PCIPLL0],
                                p[PIN_MODE1], p[PIN_MODE0], 1'b0,
                                p[PIN_SYNC],
                                p[PIN_PCIDIV0], p[PIN_PCIDIV1]};
  wire [7:0] cpu_boot_next   = {p[PIN_MULT1], p[PIN_MULT0],
                                5'h00, p[PIN_BOOTW]};
  wire [7:0] periph_next     = {p[PIN_PAR], p[PIN_KBD], 1'b0,
                                p[PIN_DCLKDIR], p[PIN_MCLKDIR],
                                p[PIN_HCLKDIR], p[PIN_SER1], p[PIN_SER2]};
  wire [7:0] host_pll_next   = {2'h0, p[PIN_HPLL2], p[PIN_HPLL1],
                                p[PIN_HPLL0], 3'h0};

  wire do_capture = !captured_reg;
  wire dot_wr     = captured_reg && cfg_wr_i && (cfg_index_i == IDX_PERIPH);

  // one-shot capture on the first edge after reset release
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      captured_reg   <= 1'b0;
      clock_mode_reg <= 8'h00;
      cpu_boot_reg   <= 8'h00;
      periph_reg     <= 8'h00;
      host_pll_reg   <= 8'h00;
      deskew_reg     <= 2'h0;
      hspd_reg       <= 2'h0;
    end
    else if (do_capture)
    begin
      captured_reg   <= 1'b1;
      clock_mode_reg <= clock_mode_next;
      cpu_boot_reg   <= cpu_boot_next;
      periph_reg     <= periph_next;
      host_pll_reg   <= host_pll_next;
      deskew_reg     <= {p[PIN_DSK0], p[PIN_DSK1]};
      hspd_reg       <= {p[PIN_HSPD1], p[PIN_HSPD0]};
    end
    else if (dot_wr)
      periph_reg[DOT_DIR_BIT] <= cfg_wdata_i[DOT_DIR_BIT];
  end

  // read decode: deskew has no index
  wire       hit_a = (cfg_index_i == IDX_CLOCK_MODE);
  wire       hit_b = (cfg_index_i == IDX_CPU_BOOT);
  wire       hit_c = (cfg_index_i == IDX_PERIPH);
  wire       hit_d = (cfg_index_i == IDX_HOST_PLL);
  wire       hit_any = hit_a | hit_b | hit_c | hit_d;
  wire [7:0] rd_mux = hit_a ? clock_mode_reg :
                      hit_b ? cpu_boot_reg :
                      hit_c ? periph_reg :
                      hit_d ? host_pll_reg : 8'h00;

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_rdata_o <= 8'h00;
      cfg_hit_o   <= 1'b0;
    end
    else
    begin
      cfg_rdata_o <= cfg_rd_i ? rd_mux : 8'h00;
      cfg_hit_o   <= cfg_rd_i & hit_any;
    end
  end

  // decoded settings
  wire [2:0]     hcode  = host_pll_reg[5:3];
  host_clk_sel_e hsel;
  assign hsel = (hspd_reg != 2'h0) ? HCLK_RSV :
                (hcode == HPLL_25) ? HCLK_25 :
                (hcode == HPLL_50) ? HCLK_50 :
                (hcode == HPLL_60) ? HCLK_60 :
                (hcode == HPLL_66) ? HCLK_66 : HCLK_RSV;

  strap_cfg_s cfg_next;
  always_comb
  begin
    cfg_next                = '0;
    cfg_next.pci_pll_range  = clock_mode_reg[7:6];
    cfg_next.pci_pll_valid  = !clock_mode_reg[7];
    cfg_next.bus_mode       = clock_mode_reg[5:4];
    cfg_next.isa_mode       = (clock_mode_reg[5:4] == MODE_ISA);
    cfg_next.mem_host_sync  = clock_mode_reg[2];
    cfg_next.pci_div        = clock_mode_reg[1:0];
    cfg_next.cpu_mult       = cpu_boot_reg[7:6];
    cfg_next.cpu_mult_valid = (cpu_boot_reg[7:6] == MULT_X1) ||
                              (cpu_boot_reg[7:6] == MULT_X2);
    cfg_next.boot_16bit     = cpu_boot_reg[0];
    cfg_next.host_pll_code  = hcode;
    cfg_next.host_clk_sel   = hsel;
    cfg_next.deskew_code    = deskew_reg;
    cfg_next.deskew_valid   = (deskew_reg == DSK_LOW) || (deskew_reg == DSK_HIGH);
    cfg_next.par_en         = periph_reg[7];
    cfg_next.kbd_en         = periph_reg[6];
    cfg_next.ser1_en        = periph_reg[1];
    cfg_next.ser2_en        = periph_reg[0];
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_cfg_o   <= '0;
      clk_pin_dir_o <= '0;
    end
    else
    begin
      strap_cfg_o                  <= cfg_next;
      clk_pin_dir_o.dot_clk_drive  <= periph_reg[DOT_DIR_BIT];
      clk_pin_dir_o.mem_clk_drive  <= periph_reg[3];
      clk_pin_dir_o.host_clk_drive <= periph_reg[2];
    end
  end

  // checks
  property p_capture;
    @(posedge ref_clk_i) disable iff (!rst_n)
    do_capture |=> clock_mode_reg == $past(clock_mode_next)
                && host_pll_reg == $past(host_pll_next);
  endproperty
  a_capture: assert property (p_capture) else $error("strap capture mismatch");

  property p_hold;
    @(posedge ref_clk_i) disable iff (!rst_n)
    captured_reg |=> $stable(clock_mode_reg) && $stable(cpu_boot_reg)
                  && $stable(host_pll_reg) && $stable(deskew_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("strap value changed after capture");

  property p_rd_a;
    @(posedge ref_clk_i) disable iff (!rst_n)
    cfg_rd_i && cfg_index_i == IDX_CLOCK_MODE |=> cfg_rdata_o == clock_mode_reg && cfg_hit_o;
  endproperty
  a_rd_a: assert property (p_rd_a) else $error("index 4a read wrong");

  property p_rsv_b;
    @(posedge ref_clk_i) disable iff (!rst_n)
    cpu_boot_reg[5:1] == 5'h00;
  endproperty
  a_rsv_b: assert property (p_rsv_b) else $error("reserved bits set");

  property p_hpll_zero;
    @(posedge ref_clk_i) disable iff (!rst_n)
    cfg_rd_i && cfg_index_i == IDX_HOST_PLL |=> cfg_rdata_o[7:6] == 2'h0;
  endproperty
  a_hpll_zero: assert property (p_hpll_zero) else $error("host pll top bits nonzero");

  property p_ro_write;
    @(posedge ref_clk_i) disable iff (!rst_n)
    captured_reg && cfg_wr_i |=> $stable(periph_reg[7:5]) && $stable(periph_reg[3:0]);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only bit written");

  property p_dot_wr;
    @(posedge ref_clk_i) disable iff (!rst_n)
    dot_wr |=> ##1 clk_pin_dir_o.dot_clk_drive == $past(cfg_wdata_i[DOT_DIR_BIT], 2);
  endproperty
  a_dot_wr: assert property (p_dot_wr) else $error("dot clock write not applied");

  property p_isa;
    @(posedge ref_clk_i) disable iff (!rst_n)
    clock_mode_reg[5:4] == MODE_ISA |=> strap_cfg_o.isa_mode;
  endproperty
  a_isa: assert property (p_isa) else $error("isa mode not reported");

  property p_no_deskew_read;
    @(posedge ref_clk_i) disable iff (!rst_n)
    cfg_rd_i && !hit_any |=> cfg_rdata_o == 8'h00 && !cfg_hit_o;
  endproperty
  a_no_deskew_read: assert property (p_no_deskew_read) else $error("unmapped read");

  // read data only stands for the cycle after a read
  property p_rd_idle;
    @(posedge ref_clk_i) disable iff (!rst_n)
    !cfg_rd_i |=> cfg_rdata_o == 8'h00 && !cfg_hit_o;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");

  property p_pin_dir;
    @(posedge ref_clk_i) disable iff (!rst_n)
    captured_reg |=> clk_pin_dir_o.mem_clk_drive == $past(periph_reg[3])
                  && clk_pin_dir_o.host_clk_drive == $past(periph_reg[2]);
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("clock pin drive wrong");

  c_capture: cover property (@(posedge ref_clk_i) disable iff (!rst_n) do_capture);
  c_rd_pll:  cover property (@(posedge ref_clk_i) cfg_rd_i && hit_d);
  c_dot_wr:  cover property (@(posedge ref_clk_i) dot_wr);
  c_isa:     cover property (@(posedge ref_clk_i) strap_cfg_o.isa_mode);
endmodule

// ### bench/strap_board_model.sv
// board side of the strap pins: resistor levels while hold_straps_i is high, bus traffic after
// assumes the bench says when the memory data bus starts carrying traffic
`timescale 1ns/1ps
module strap_board_model
(
  input  wire logic        ref_clk_i,
  input  wire logic        hold_straps_i,
  input  wire logic [63:0] straps_i,
  output logic      [63:0] pins_o
);
  logic [63:0] traffic_reg;

  // traffic toggles every cycle so a late or repeated sample shows up
  always_ff @(posedge ref_clk_i)
  begin
    traffic_reg <= hold_straps_i ? ~straps_i : ~traffic_reg;
  end

  assign pins_o = hold_straps_i ? straps_i : traffic_reg;
endmodule

// ### bench/strap_option_capture_regs_tb.sv
// self-checking bench for the strap option capture registers
// assumes the design package and a board model that drives the strap pins
`timescale 1ns/1ps
module strap_option_capture_regs_tb;
  import strap_capture_pkg::*;
  logic         ref_clk_i   = 1'b0;
  logic         reset_n_i   = 1'b0;
  logic         hold        = 1'b1;
  logic [63:0]  s           = 64'h0;
  logic [63:0]  pins;
  logic [7:0]   cfg_index_i = 8'h00;
  logic         cfg_rd_i    = 1'b0;
  logic         cfg_wr_i    = 1'b0;
  logic [7:0]   cfg_wdata_i = 8'h00;
  logic [7:0]   cfg_rdata_o;
  logic         cfg_hit_o;
  strap_cfg_s   cfg;
  clk_pin_dir_s dir;
  logic [8:0]   exp_q[$];
  logic         pend        = 1'b0;
  logic         dot         = 1'b0;
  int           bad_count   = 0;
  int           check_count = 0;
  int           seed        = 32'h7335;

  strap_board_model i_strap_board_model
  (
    .ref_clk_i     (ref_clk_i),
    .hold_straps_i (hold),
    .straps_i      (s),
    .pins_o        (pins)
  );

  strap_option_capture_regs i_strap_option_capture_regs
  (
    .ref_clk_i                (ref_clk_i),
    .reset_n_i                (reset_n_i),
    .memory_data_strap_pins_i (pins),
    .cfg_index_i              (cfg_index_i),
    .cfg_rd_i                 (cfg_rd_i),
    .cfg_wr_i                 (cfg_wr_i),
    .cfg_wdata_i              (cfg_wdata_i),
    .cfg_rdata_o              (cfg_rdata_o),
    .cfg_hit_o                (cfg_hit_o),
    .strap_cfg_o              (cfg),
    .clk_pin_dir_o            (dir)
  );

  initial
  begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic end_sim();
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] reg_val(input logic [7:0] idx);
    case (idx)
      8'h4a:   reg_val = {s[7], s[6], s[9], s[8], 1'b0, s[5], s[4], s[17]};
      8'h4b:   reg_val = {s[40], s[14], 5'h00, s[36]};
      8'h4c:   reg_val = {s[53], s[52], 1'b0, dot, s[19], s[18], s[51], s[50]};
      8'h5f:   reg_val = {2'h0, s[26], s[25], s[24], 3'h0};
      default: reg_val = 8'h00;
    endcase
  endfunction

  function automatic host_clk_sel_e hsel();
    if (s[3:2] != 2'h0 || s[26])
      hsel = HCLK_RSV;
    else
      case (s[25:24])
        2'h0:    hsel = HCLK_25;
        2'h1:    hsel = HCLK_50;
        2'h2:    hsel = HCLK_60;
        default: hsel = HCLK_66;
      endcase
  endfunction

  task automatic rd(input logic [7:0] idx);
    @(posedge ref_clk_i);
    cfg_index_i <= idx;
    cfg_rd_i    <= 1'b1;
    cfg_wr_i    <= 1'b0;
    exp_q.push_back({idx inside {8'h4a, 8'h4b, 8'h4c, 8'h5f}, reg_val(idx)});
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    @(posedge ref_clk_i);
    cfg_index_i <= idx;
    cfg_wdata_i <= data;
    cfg_wr_i    <= 1'b1;
    cfg_rd_i    <= 1'b0;
    if (idx == 8'h4c)
      dot = data[4];
  endtask

  task automatic idle();
    @(posedge ref_clk_i);
    cfg_rd_i <= 1'b0;
    cfg_wr_i <= 1'b0;
  endtask

  task automatic check_cfg();
    check(9'(cfg.pci_pll_range), 9'({s[7], s[6]}));
    check(9'(cfg.pci_pll_valid), 9'(!s[7]));
    check(9'(cfg.bus_mode), 9'({s[9], s[8]}));
    check(9'(cfg.isa_mode), 9'(s[9:8] == 2'h0));
    check(9'(cfg.mem_host_sync), 9'(s[5]));
    check(9'(cfg.pci_div), 9'({s[4], s[17]}));
    check(9'(cfg.cpu_mult), 9'({s[40], s[14]}));
    check(9'(cfg.cpu_mult_valid), 9'(s[14]));
    check(9'(cfg.boot_16bit), 9'(s[36]));
    check(9'(cfg.host_pll_code), 9'(s[26:24]));
    check(9'(cfg.host_clk_sel), 9'(hsel()));
    check(9'(cfg.deskew_code), 9'({s[45], s[46]}));
    check(9'(cfg.deskew_valid), 9'(s[45] ^ s[46]));
    check(9'({cfg.par_en, cfg.kbd_en, cfg.ser1_en, cfg.ser2_en}),
          9'({s[53], s[52], s[51], s[50]}));
    check(9'(dir), 9'({dot, s[19], s[18]}));
  endtask

  // read results arrive one cycle after the read edge
  always @(posedge ref_clk_i)
  begin
    if (pend)
      check({cfg_hit_o, cfg_rdata_o}, exp_q.pop_front());
    else if (reset_n_i)
      check({cfg_hit_o, cfg_rdata_o}, 9'h000);
    pend = reset_n_i & cfg_rd_i;
  end

  initial
  begin
    repeat (5000) @(posedge ref_clk_i);
    bad_count++;
    end_sim();
  end

  initial
  begin
    logic [63:0] v;
    for (int i = 0; i < 10; i++)
    begin
      @(posedge ref_clk_i);
      v = {$random(seed), $random(seed)};
      if (i < 8)
      begin
        v[3:2]   = 2'h0;
        v[26:24] = i[2:0];
      end
      v[46:45]  = i[1:0];
      v[40]     = i[1];
      v[14]     = i[0];
      v[9:8]    = i[2:1];
      s         <= v;
      hold      <= 1'b1;
      reset_n_i <= 1'b0;
      dot       = v[20];
      repeat (2) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      hold <= 1'b0;
      #1;
      check_cfg();
      rd(8'h4a);
      rd(8'h4b);
      rd(8'h4c);
      rd(8'h5f);
      rd(8'h4d);
      rd(8'h22);
      wr(8'h4a, 8'hff);
      wr(8'h4c, ~reg_val(8'h4c));
      wr(8'h4b, 8'hff);
      wr(8'h5f, 8'hff);
      rd(8'h4c);
      rd(8'h4a);
      rd(8'h4b);
      rd(8'h5f);
      idle();
      @(posedge ref_clk_i);
      #1;
      check_cfg();
    end
    repeat (3) @(posedge ref_clk_i);
    end_sim();
  end
endmodule
